// >>> src/asram_ctrl.sv
// Purpose: Host side controller sequencing an asynchronous 32K x 8 SRAM.
// Assumes: One 200 MHz clock, synchronous active-high reset, pins synchronous.
// Notes:   One access at a time; the request is taken only when ready is high.
// Operation
// - Address stable, strobe low long enough.
// - Selects asserted long enough before write end.
// - Write data set up and held.
// - Address moves only with strobe inactive.
// - Controller never drives against device outputs.
// - Strobe stays high through every read.
`timescale 1ns/1ps
module asram_ctrl #(
  parameter int unsigned SLOW_GRADE = 0
) (
  input  wire logic                           ref_clk_i,
  input  wire logic                           srst_i,
  input  wire logic                           req_valid_i,
  input  wire logic                           req_write_i,
  input  wire logic [asram_pkg::ADDR_W-1:0]   req_addr_i,
  input  wire logic [asram_pkg::DATA_W-1:0]   req_wdata_i,
  output logic                                req_ready_o,
  output logic                                rsp_valid_o,
  output logic      [asram_pkg::DATA_W-1:0]   rsp_rdata_o,
  output logic      [asram_pkg::ADDR_W-1:0]   word_address_o,
  output logic                                select_n_o,
  output logic                                select_hi_o,
  output logic                                write_n_o,
  output logic      [asram_pkg::DATA_W-1:0]   data_pins_o,
  output logic                                data_pins_oe_n_o,
  input  wire logic [asram_pkg::DATA_W-1:0]   data_pins_i
);
  import asram_pkg::*;

  // Only two speed grades exist; any value other than 0 or 1 is flagged as an elaboration error.
  if (SLOW_GRADE > 1) begin : g_bad_grade
    $error("SLOW_GRADE must be 0 or 1");
  end

  localparam logic [CNT_W-1:0] RD_CYC = (SLOW_GRADE != 0) ? RD_SLOW_CYC : RD_FAST_CYC;
  localparam logic [CNT_W-1:0] WP_CYC = (SLOW_GRADE != 0) ? WP_SLOW_CYC : WP_FAST_CYC;
  localparam logic [CNT_W-1:0] DW_CYC = (SLOW_GRADE != 0) ? DW_SLOW_CYC : DW_FAST_CYC;

  asram_state_type   st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  asram_pins_type    pin_q, pin_d;
  logic              rdy_q, rdy_d;
  logic              rv_q, rv_d;
  logic [DATA_W-1:0] rd_q, rd_d;

  // Next-state logic for the access sequencer and the pin bundle.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    pin_d = pin_q;
    rdy_d = rdy_q;
    rv_d  = 1'b0;
    rd_d  = rd_q;
    case (st_q)
      ST_IDLE: begin
        if (req_valid_i && rdy_q) begin
          pin_d.word_address = req_addr_i;
          rdy_d              = 1'b0;
          cnt_d              = CNT_ONE;
          if (req_write_i) begin
            pin_d.data_out  = req_wdata_i;
            pin_d.data_oe_n = 1'b0;
            st_d            = ST_WSET;
          end else begin
            pin_d.select_n  = 1'b0;
            pin_d.select_hi = 1'b1;
            pin_d.write_n   = 1'b1;
            st_d            = ST_READ;
          end
        end else if (!rdy_q) begin
          // Ready comes back one cycle after reset leaves the sequencer idle.
          rdy_d = 1'b1;
        end
      end
      ST_READ: begin
        if (cnt_q >= RD_CYC) begin
          rd_d            = data_pins_i;
          rv_d            = 1'b1;
          pin_d.select_n  = 1'b1;
          pin_d.select_hi = 1'b0;
          cnt_d           = CNT_ONE;
          st_d            = ST_TURN;
        end else begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end
      ST_WSET: begin
        // Address settled a cycle; now both selects assert and the strobe falls, all together.
        pin_d.select_n  = 1'b0;
        pin_d.select_hi = 1'b1;
        pin_d.write_n   = 1'b0;
        cnt_d           = CNT_ONE;
        st_d            = ST_WRITE;
      end
      ST_WRITE: begin
        if (cnt_q >= WP_CYC && cnt_q >= DW_CYC) begin
          pin_d.write_n   = 1'b1;
          pin_d.select_n  = 1'b1;
          pin_d.select_hi = 1'b0;
          cnt_d           = CNT_ONE;
          st_d            = ST_TURN;
        end else begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end
      ST_TURN: begin
        // Data is held one cycle past write end, then bus released.
        pin_d.data_oe_n = 1'b1;
        if (cnt_q >= TURN_CYC) begin
          rdy_d = 1'b1;
          st_d  = ST_IDLE;
        end else begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Register stage; every pin comes from a flip-flop.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q  <= ST_IDLE;
      cnt_q <= '0;
      pin_q <= '{word_address: '0, select_n: 1'b1, select_hi: 1'b0, write_n: 1'b1,
                 data_out: '0, data_oe_n: 1'b1};
      rdy_q <= 1'b0;
      rv_q  <= 1'b0;
      rd_q  <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      pin_q <= pin_d;
      rdy_q <= rdy_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
    end
  end

  assign req_ready_o      = rdy_q;
  assign rsp_valid_o      = rv_q;
  assign rsp_rdata_o      = rd_q;
  assign word_address_o   = pin_q.word_address;
  assign select_n_o       = pin_q.select_n;
  assign select_hi_o      = pin_q.select_hi;
  assign write_n_o        = pin_q.write_n;
  assign data_pins_o      = pin_q.data_out;
  assign data_pins_oe_n_o = pin_q.data_oe_n;

  // address stable selected
  // A read moves the address with the strobe high, which keeps the device from writing.
  a_addr_while_sel: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!$stable(word_address_o)) |->
      ($past(select_n_o) || !$past(select_hi_o) || $past(write_n_o))
      && (select_n_o || !select_hi_o || write_n_o))
    else $error("address moved while selected");

  a_no_contention: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!select_n_o && write_n_o) |-> data_pins_oe_n_o)
    else $error("controller drives during read");

  a_read_strobe_hi: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (st_q == ST_READ) |-> write_n_o)
    else $error("strobe low in read");

  // Counting the low time in a helper keeps the check cheap for the slow grade too.
  // The count saturates, so a stuck strobe cannot wrap back to a short-looking pulse.
  logic [CNT_W-1:0] wlow_q, wlow_d;

  always_comb begin
    wlow_d = wlow_q;
    if (write_n_o) begin
      wlow_d = '0;
    end else if (wlow_q != '1) begin
      wlow_d = wlow_q + CNT_ONE;
    end
  end

  // Register stage of the strobe low count.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wlow_q <= '0;
    end else begin
      wlow_q <= wlow_d;
    end
  end

  a_strobe_width: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(write_n_o) |-> (wlow_q >= WP_CYC))
    else $error("strobe pulse too short");

  a_data_held: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(write_n_o) |-> !data_pins_oe_n_o && $stable(data_pins_o))
    else $error("write data not held");

  a_sel_in_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!write_n_o) |-> (!select_n_o && select_hi_o))
    else $error("select dropped during write");

  // response window bounds follow the grade's read count.
  localparam int RSP_LO = RD_CYC - 8;
  localparam int RSP_HI = RD_CYC - 5;

  a_read_len: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $fell(select_n_o) && write_n_o |-> (!select_n_o)[*8] ##[RSP_LO:RSP_HI] rsp_valid_o)
    else $error("read too short or too long");

  a_rsp_pulse: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("response longer than one cycle");

endmodule

// >>> src/asram_pkg.sv
// Purpose: Shared constants and types for the asynchronous SRAM host controller.
// Assumes: Controller clock of 200 MHz (5 ns period).
// Notes:   All timing figures are kept in ns; those the controller uses are converted to cycles here.
package asram_pkg;

  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Fast grade figures, in ns.
  localparam int unsigned RC_FAST_NS  = 70;
  localparam int unsigned AA_FAST_NS  = 70;
  localparam int unsigned WC_FAST_NS  = 70;
  localparam int unsigned AW_FAST_NS  = 50;
  localparam int unsigned WP_FAST_NS  = 55;
  localparam int unsigned DW_FAST_NS  = 30;
  // Slow grade figures, in ns.
  localparam int unsigned RC_SLOW_NS  = 85;
  localparam int unsigned AA_SLOW_NS  = 85;
  localparam int unsigned WC_SLOW_NS  = 85;
  localparam int unsigned AW_SLOW_NS  = 70;
  localparam int unsigned WP_SLOW_NS  = 65;
  localparam int unsigned DW_SLOW_NS  = 35;
  // Grade independent figures, in ns.
  localparam int unsigned HZ_NS       = 30;
  localparam int unsigned OW_NS       = 10;

  // Least times round up to whole cycles.
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CNT_W = 5;

  localparam logic [CNT_W-1:0] RD_FAST_CYC = CNT_W'(ns_to_cyc(RC_FAST_NS));
  localparam logic [CNT_W-1:0] RD_SLOW_CYC = CNT_W'(ns_to_cyc(RC_SLOW_NS));
  // Write strobe low time must cover pulse width, address and select to end.
  localparam logic [CNT_W-1:0] WP_FAST_CYC = CNT_W'(ns_to_cyc(WP_FAST_NS));
  localparam logic [CNT_W-1:0] WP_SLOW_CYC = CNT_W'(ns_to_cyc(AW_SLOW_NS));
  localparam logic [CNT_W-1:0] DW_FAST_CYC = CNT_W'(ns_to_cyc(DW_FAST_NS));
  localparam logic [CNT_W-1:0] DW_SLOW_CYC = CNT_W'(ns_to_cyc(DW_SLOW_NS));
  // Turnaround gap covering output release after a read.
  localparam logic [CNT_W-1:0] TURN_CYC    = CNT_W'(ns_to_cyc(HZ_NS));
  localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

  // Pin bundle towards the memory.
  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic              select_n;
    logic              select_hi;
    logic              write_n;
    logic [DATA_W-1:0] data_out;
    logic              data_oe_n;
  } asram_pins_type;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WSET  = 5'h04,
    ST_WRITE = 5'h08,
    ST_TURN  = 5'h10
  } asram_state_type;

endpackage

// >>> verification/asram_sram_model.sv
// Purpose: Behavioural 32K x 8 asynchronous SRAM, fast grade, facing the controller pins.
// Assumes: Controller pins move on clock edges at half nanoseconds; bus is set on a 0.5 ns grid.
// Notes:   A released bus toggles every step, so a stale or early sample cannot match.
`timescale 1ns/1ps
module asram_sram_model (
  input  wire logic [asram_pkg::ADDR_W-1:0] word_address_i,
  input  wire logic                         select_n_i,
  input  wire logic                         select_hi_i,
  input  wire logic                         write_n_i,
  input  wire logic [asram_pkg::DATA_W-1:0] ctrl_data_i,
  input  wire logic                         ctrl_oe_n_i,
  output logic      [asram_pkg::DATA_W-1:0] bus_o,
  output int                                fault_count_o
);
  import asram_pkg::*;
  logic [DATA_W-1:0] mem_q [0:32767];
  realtime           t_sel = -1.0E3, t_adr = -1.0E3, t_wef = -1.0E3;
  realtime           t_wer = -1.0E3, t_dat = -1.0E3;
  logic              sel = 1'b0, wr = 1'b0, wr_p = 1'b0, late_q = 1'b0, drv;
  logic [DATA_W-1:0] old_q = 8'h00;

  // Stamp pin events; a moving address under an open write is a fault.
  always @(word_address_i) begin
    old_q = bus_o;
    t_adr = $realtime;
    if (!select_n_i && select_hi_i && !write_n_i) fault_count_o++;
  end
  always @(ctrl_data_i, ctrl_oe_n_i) t_dat = $realtime;
  always @(negedge write_n_i) t_wef = $realtime;
  always @(posedge write_n_i) t_wer = $realtime;

  // Track selection and judge each write at the moment it ends.
  always @(select_n_i, select_hi_i, write_n_i) begin
    if (!select_n_i && select_hi_i && !sel) begin
      t_sel  = $realtime;
      late_q = !write_n_i;
    end
    sel = !select_n_i && select_hi_i;
    wr  = sel && !write_n_i;
    if (wr_p && !wr) begin
      if ($realtime - t_wef < 55 || $realtime - t_adr < 50 || $realtime - t_sel < 50
          || $realtime - t_dat < 30 || ctrl_oe_n_i) fault_count_o++;
      mem_q[word_address_i] = ctrl_data_i;
    end
    if (!sel) late_q = 1'b0;
    wr_p = wr;
  end

  // Resolve the bus a quarter nanosecond off the clock edges, so no update races an edge.
  initial begin
    fault_count_o = 0;
    bus_o = 8'h00;
    for (int i = 0; i < 32768; i++) begin
      mem_q[i] = 8'hA5 ^ i[7:0];
    end
    #0.25;
    forever begin
      drv = sel && write_n_i && !late_q && $realtime - t_sel >= 10.0
            && $realtime - t_wer >= 10.0;
      if (drv && !ctrl_oe_n_i) fault_count_o++;
      bus_o = !ctrl_oe_n_i ? ctrl_data_i : !drv ? ~bus_o : ($realtime - t_adr < 10) ? old_q :
              ($realtime - t_sel >= 69.5 && $realtime - t_adr >= 69.5) ?
              mem_q[word_address_i] : ~mem_q[word_address_i];
      #0.5;
    end
  end
endmodule

// >>> verification/async_sram_32k_by_8_tb_top.sv
// Purpose: Self-checking bench for the SRAM host controller against a device model.
// Assumes: Fast grade, 200 MHz clock, bench inputs change on falling edges.
// Notes:   Read latency is a fixed 15 edges: 14 cycles of access time plus the response register.
`timescale 1ns/1ps
module async_sram_32k_by_8_tb_top;
  import asram_pkg::*;
  logic              clk = 1'b0, srst = 1'b1, valid = 1'b0, write = 1'b0;
  logic [ADDR_W-1:0] addr = '0, waddr;
  logic [DATA_W-1:0] wdata = '0, rdata, dout, din, q;
  logic              ready, rsp, seln, selhi, wrn, oen;
  int                faults, lat, miscompares = 0, checks_done = 0;

  always #2.5 clk = ~clk;

  asram_ctrl #(.SLOW_GRADE(0)) i_dut (.ref_clk_i(clk), .srst_i(srst), .req_valid_i(valid),
    .req_write_i(write), .req_addr_i(addr), .req_wdata_i(wdata), .req_ready_o(ready),
    .rsp_valid_o(rsp), .rsp_rdata_o(rdata), .word_address_o(waddr), .select_n_o(seln),
    .select_hi_o(selhi), .write_n_o(wrn), .data_pins_o(dout), .data_pins_oe_n_o(oen),
    .data_pins_i(din));
  asram_sram_model i_mem (.word_address_i(waddr), .select_n_i(seln), .select_hi_i(selhi),
    .write_n_i(wrn), .ctrl_data_i(dout), .ctrl_oe_n_i(oen), .bus_o(din), .fault_count_o(faults));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request; a read is timed, and junk keeps a write offered while busy.
  task automatic do_op(input logic wr, input logic [14:0] a, input logic [7:0] d, input logic junk);
    int n;
    logic strobe_low;
    n = 0;
    strobe_low = 1'b0;
    while (ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    {valid, write, addr, wdata} = {1'b1, wr, a, d};
    @(negedge clk);
    {valid, write, wdata} = {junk, junk, ~d};
    lat = 1;
    while (!wr && rsp !== 1'b1 && lat < 40) begin
      strobe_low |= !wrn;
      @(negedge clk);
      lat++;
    end
    valid = 1'b0;
    q = rdata;
    check("strobe low in read", {15'h0, strobe_low}, 16'h0);
  endtask

  task automatic t_reset();
    repeat (8) @(negedge clk);
    check("pins in reset", {ready, seln, selhi, wrn, oen}, 16'h000B);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    check("ready after reset", ready, 16'h1);
    $display("test reset done");
  endtask

  task automatic t_rw();
    logic [14:0] at [4] = '{15'h0000, 15'h7FFF, 15'h2AAA, 15'h5555};
    logic [7:0]  dt [4] = '{8'h5A, 8'hC3, 8'hFF, 8'h00};
    for (int i = 0; i < 4; i++) begin
      do_op(1'b1, at[i], dt[i], 1'b0);
      do_op(1'b0, at[i], 8'h00, 1'b0);
      check("read back", q, dt[i]);
      check("read latency", lat[15:0], 16'(RC_FAST_NS / CLK_PERIOD_NS + 1));
    end
    $display("test write read done");
  endtask

  task automatic t_refused();
    do_op(1'b0, 15'h0100, 8'h3C, 1'b1);
    check("busy read", q, 16'h00A5);
    do_op(1'b0, 15'h0100, 8'h00, 1'b0);
    check("refused write", q, 16'h00A5);
    check("model faults", faults[15:0], 16'h0);
    $display("test refused done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cut a hang short; the tests need only a few hundred cycles.
  initial begin
    #50000;
    miscompares++;
    final_report();
  end

  // Main sequence of scenarios.
  initial begin
    t_reset();
    t_rw();
    t_refused();
    final_report();
  end
endmodule
